/* src/stomon_discrep_timer.sv */
/*
 * Discrepancy timer: counts cycles while the two cutoff inputs disagree.
 * Assumes inputs already synchronous to sys_clk_i.
 */
`timescale 1ns/100ps
module stomon_discrep_timer
    import stomon_pkg::*;
#(
    parameter int unsigned LIMIT = DISCREP_CYC
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic disagree_i,
    output logic      expired_o
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             exp_q;
    logic             exp_d;

    always_comb begin
        cnt_d = cnt_q;
        exp_d = 1'b0;
        if (!disagree_i) begin
            cnt_d = '0;
        end else if (cnt_q >= CNT_W'(LIMIT)) begin
            exp_d = 1'b1;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign expired_o = exp_q;
endmodule

/* src/stomon_pkg.sv */
/*
 * Constants for the torque cutoff supervision block: timing, fault codes, states.
 * Assumes a 200 MHz system clock.
 */
package stomon_pkg;
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned RESPONSE_MAX_US  = 1000;
    localparam int unsigned RESPONSE_CYC     = RESPONSE_MAX_US * CLK_MHZ;
    localparam int unsigned DISCREP_MS       = 200;
    localparam int unsigned DISCREP_CYC      = DISCREP_MS * 1000 * CLK_MHZ;
    localparam int unsigned CNT_W            = 26;
    localparam logic [7:0]  FC_NONE          = 8'h00;
    localparam logic [7:0]  FC_DISCREPANCY   = 8'h17;
    localparam logic [7:0]  FC_TORQUE_CUTOFF = 8'h42;
    localparam logic        GATE_EN_RESET    = 1'b0;

    typedef enum logic [1:0] {
        STOMON_STOPPED = 2'b00,
        STOMON_RUNNING = 2'b01,
        STOMON_TRIPPED = 2'b10
    } stomon_state_e;
endpackage

/* src/stomon_top.sv */
/*
 * Torque cutoff supervision: watches two normally-closed cutoff inputs,
 * forces gate drives off, latches fault codes, checks input agreement.
 * Assumes inputs synchronous to sys_clk_i; input high means closed.
 */
// Summary of operation
// - On cutoff demand trip at once and remove motor drive; motor coasts.
// - While cutoff active, gate drives held off regardless of software control.
// - Motor power removed within 1 ms of an input opening.
// - Disagreement tolerated 200 ms; after that raise discrepancy fault.
// - One input open: stop, report discrepancy code 23 and cutoff code 66.
// - Both inputs open together: stop, report only cutoff code 66.
// - Internal circuit failure also raises the discrepancy fault.
`timescale 1ns/100ps
module stomon_top
    import stomon_pkg::*;
#(
    parameter int unsigned DISCREP_LIMIT = DISCREP_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       torque_cutoff_input_a_i,
    input  wire logic       torque_cutoff_input_b_i,
    input  wire logic       run_cmd_i,
    input  wire logic       stop_cmd_i,
    input  wire logic       sw_gate_en_i,
    input  wire logic       internal_fail_i,
    input  wire logic       fault_clear_i,
    output logic            gate_drive_en_o,
    output logic            torque_cutoff_function_o,
    output logic            drive_trip_o,
    output logic            cutoff_discrepancy_fault_o,
    output logic            cutoff_fault_o,
    output logic [7:0]      fault_code_o
);
    stomon_state_e state_q;
    stomon_state_e state_d;
    logic          gate_q;
    logic          gate_d;
    logic          cut_q;
    logic          cut_d;
    logic          trip_q;
    logic          trip_d;
    logic          disc_q;
    logic          disc_d;
    logic          cfault_q;
    logic          cfault_d;
    logic [7:0]    code_q;
    logic [7:0]    code_d;
    logic          expired;
    logic          any_open;
    logic          one_open;
    logic          both_open;

    // Open means low on a normally-closed line
    function automatic logic line_open(input logic line);
        return !line;
    endfunction

    // Code priority: discrepancy over cutoff over held value
    function automatic logic [7:0] next_code(input logic       disc_set,
                                             input logic       cut_set,
                                             input logic [7:0] held);
        logic [7:0] code;
        code = held;
        if (cut_set) begin
            code = FC_TORQUE_CUTOFF;
        end
        if (disc_set) begin
            code = FC_DISCREPANCY;
        end
        return code;
    endfunction

    // Any opening is a demand
    assign any_open  = line_open(torque_cutoff_input_a_i)
                    || line_open(torque_cutoff_input_b_i);
    assign both_open = line_open(torque_cutoff_input_a_i)
                    && line_open(torque_cutoff_input_b_i);
    assign one_open  = any_open && !both_open;

    stomon_discrep_timer #(
        .LIMIT (DISCREP_LIMIT)
    ) u_timer (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .disagree_i (one_open),
        .expired_o  (expired)
    );

    // Run state and sticky trip
    always_comb begin
        state_d = state_q;
        trip_d  = trip_q;
        case (state_q)
            STOMON_RUNNING: begin
                if (any_open) begin
                    state_d = STOMON_TRIPPED;
                    trip_d  = 1'b1;
                end else if (stop_cmd_i) begin
                    state_d = STOMON_STOPPED;
                end
            end
            STOMON_TRIPPED: begin
                // Restart only from stopped with a fresh run command
                if (!any_open) begin
                    state_d = STOMON_STOPPED;
                end
            end
            STOMON_STOPPED: begin
                if (any_open) begin
                    state_d = STOMON_TRIPPED;
                    trip_d  = 1'b1;
                end else if (run_cmd_i) begin
                    state_d = STOMON_RUNNING;
                    trip_d  = 1'b0;
                end
            end
            default: begin
                state_d = STOMON_TRIPPED;
                trip_d  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= STOMON_STOPPED;
            trip_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            trip_q  <= trip_d;
        end
    end

    // Sticky fault flags and latest code; a set beats a clear in one cycle
    always_comb begin
        disc_d   = disc_q;
        cfault_d = cfault_q;
        code_d   = code_q;
        if (fault_clear_i) begin
            disc_d   = 1'b0;
            cfault_d = 1'b0;
            code_d   = FC_NONE;
        end
        if (any_open) begin
            cfault_d = 1'b1;
        end
        if (expired || internal_fail_i) begin
            disc_d = 1'b1;
        end
        code_d = next_code(expired || internal_fail_i, any_open, code_d);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            disc_q   <= 1'b0;
            cfault_q <= 1'b0;
            code_q   <= FC_NONE;
        end else begin
            disc_q   <= disc_d;
            cfault_q <= cfault_d;
            code_q   <= code_d;
        end
    end

    // Hardware gate, ANDed with software enable; an open input forces it off
    always_comb begin
        cut_d  = any_open;
        gate_d = (state_d == STOMON_RUNNING) && !any_open && sw_gate_en_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            gate_q <= GATE_EN_RESET;
            cut_q  <= 1'b0;
        end else begin
            gate_q <= gate_d;
            cut_q  <= cut_d;
        end
    end

    assign gate_drive_en_o            = gate_q;
    assign torque_cutoff_function_o   = cut_q;
    assign drive_trip_o               = trip_q;
    assign cutoff_discrepancy_fault_o = disc_q;
    assign cutoff_fault_o             = cfault_q;
    assign fault_code_o               = code_q;

    gate_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        any_open |=> !gate_drive_en_o)
        else $error("gate drive enabled while cutoff input open");

    gate_run_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        gate_drive_en_o |-> state_q == STOMON_RUNNING && !torque_cutoff_function_o)
        else $error("gate drive enabled outside running state");

    trip_now_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (any_open && state_q == STOMON_RUNNING) |=> drive_trip_o && state_q == STOMON_TRIPPED)
        else $error("no trip on cutoff demand");

    resp_time_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ($fell(torque_cutoff_input_a_i) || $fell(torque_cutoff_input_b_i))
            |-> ##[1:2] !gate_drive_en_o)
        else $error("motor power not removed in time");

    disc_quiet_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!one_open && !expired && !internal_fail_i && !cutoff_discrepancy_fault_o) |=>
            !cutoff_discrepancy_fault_o)
        else $error("discrepancy fault without cause");

    cutoff_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        one_open |=> cutoff_fault_o && torque_cutoff_function_o)
        else $error("single open input not flagged");

    both_code_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!torque_cutoff_input_a_i && !torque_cutoff_input_b_i && !internal_fail_i
            && !expired) |=> fault_code_o == FC_TORQUE_CUTOFF)
        else $error("wrong code for both inputs open");

    both_nodisc_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (both_open && !expired && !internal_fail_i && !cutoff_discrepancy_fault_o) |=>
            !cutoff_discrepancy_fault_o)
        else $error("discrepancy fault on joint opening");

    internal_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        internal_fail_i |=> cutoff_discrepancy_fault_o && fault_code_o == FC_DISCREPANCY)
        else $error("internal failure not reported");

    no_restart_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_q != STOMON_RUNNING && !run_cmd_i) |=> state_q != STOMON_RUNNING)
        else $error("running without a run command");

    trip_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (drive_trip_o && !(state_q == STOMON_STOPPED && run_cmd_i)) |=> drive_trip_o)
        else $error("trip cleared without a run command");
endmodule

/* test/stomon_estop_model.sv */
/*
 * Emergency stop partner: two separate normally-closed safety outputs.
 * Assumes the bench asks for openings on the system clock.
 */
`timescale 1ns/100ps
module stomon_estop_model (
    input  wire logic sys_clk_i,
    input  wire logic open_a_i,
    input  wire logic open_b_i,
    output logic      line_a_o,
    output logic      line_b_o
);
    // Own flop per output, closed unless asked
    always_ff @(posedge sys_clk_i) begin
        line_a_o <= !open_a_i;
        line_b_o <= !open_b_i;
    end
endmodule

/* test/tb.sv */
/*
 * Self-checking bench for the torque cutoff supervision block.
 * Assumes the stop switch model and a shortened discrepancy limit.
 */
`timescale 1ns/100ps
module tb;
    import stomon_pkg::*;
    localparam int unsigned LIM = 20;
    logic       sys_clk_i = 0, rst_i = 1, open_a = 0, open_b = 0, run_cmd = 0;
    logic       sw_gate_en = 1, int_fail = 0, f_clear = 0, stop_cmd = 0, line_a, line_b;
    logic       gate_en, cut_fn, trip, disc, cut_f;
    logic [7:0] code, code_prev, rnd = 8'h51;
    logic [7:0] exp_q[$];
    int         err_count = 0, n_compared = 0, cyc = 0, s;
    always #2.5 sys_clk_i = ~sys_clk_i;
    stomon_estop_model stomon_estop_model_i (.sys_clk_i(sys_clk_i), .open_a_i(open_a),
        .open_b_i(open_b), .line_a_o(line_a), .line_b_o(line_b));
    stomon_top #(.DISCREP_LIMIT(LIM)) stomon_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .torque_cutoff_input_a_i(line_a), .torque_cutoff_input_b_i(line_b),
        .run_cmd_i(run_cmd), .stop_cmd_i(stop_cmd), .sw_gate_en_i(sw_gate_en),
        .internal_fail_i(int_fail), .fault_clear_i(f_clear), .gate_drive_en_o(gate_en),
        .torque_cutoff_function_o(cut_fn), .drive_trip_o(trip),
        .cutoff_discrepancy_fault_o(disc), .cutoff_fault_o(cut_f), .fault_code_o(code));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic chk_bit(input logic act, input logic exp, input string what);
        n_compared++;
        if (act !== exp) begin
            err_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic chk_code(input logic [7:0] act, input logic [7:0] exp);
        n_compared++;
        if (act !== exp) begin
            err_count++;
            $display("BAD %0t code %h expected %h", $time, act, exp);
        end
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic run_up;
        run_cmd <= 1'b1;
        cyc_n(1);
        run_cmd <= 1'b0;
        cyc_n(3);
        chk_bit(gate_en, 1'b1, "gate not on after run");
        chk_bit(trip, 1'b0, "trip not cleared");
    endtask
    task automatic close_clear_run;
        open_a <= 1'b0;
        open_b <= 1'b0;
        cyc_n(6);
        chk_bit(gate_en, 1'b0, "restart without run");
        chk_bit(cut_fn, 1'b0, "cutoff shown after close");
        exp_q.push_back(FC_NONE);
        f_clear <= 1'b1;
        cyc_n(1);
        f_clear <= 1'b0;
        run_up();
    endtask
    task conclude;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watches fault code changes against the noted expectations
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        code_prev <= code;
        if (cyc == 3000) begin
            err_count++;
            conclude();
        end
        if (!rst_i && code !== code_prev) begin
            if (exp_q.size() == 0)
                chk_code(code, 8'hFF);
            else
                chk_code(code, exp_q.pop_front());
        end
    end
    initial begin
        cyc_n(5);
        rst_i <= 1'b0;
        cyc_n(2);
        run_up();
        // One input open, side picked at random
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            exp_q.push_back(FC_TORQUE_CUTOFF);
            exp_q.push_back(FC_DISCREPANCY);
            if (rnd[0]) open_a <= 1'b1;
            else open_b <= 1'b1;
            cyc_n(4);
            chk_bit(gate_en, 1'b0, "gate still on");
            chk_bit(trip, 1'b1, "no trip");
            chk_bit(cut_fn, 1'b1, "cutoff not shown");
            cyc_n(10);
            chk_bit(disc, 1'b0, "discrepancy too early");
            cyc_n(LIM);
            chk_bit(disc, 1'b1, "no discrepancy");
            chk_bit(cut_f, 1'b1, "no cutoff fault");
            close_clear_run();
        end
        // Both open, together and with a skew inside the window
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            s = (k == 0) ? 0 : 1 + rnd % 10;
            exp_q.push_back(FC_TORQUE_CUTOFF);
            open_a <= 1'b1;
            if (s > 0) cyc_n(s);
            open_b <= 1'b1;
            cyc_n(LIM + 8);
            chk_bit(disc, 1'b0, "discrepancy on joint open");
            chk_bit(cut_f, 1'b1, "no cutoff fault");
            chk_bit(gate_en, 1'b0, "gate still on");
            close_clear_run();
        end
        // Internal failure, with a clear in the same cycle that must lose
        exp_q.push_back(FC_DISCREPANCY);
        int_fail <= 1'b1;
        cyc_n(1);
        f_clear <= 1'b1;
        cyc_n(1);
        f_clear <= 1'b0;
        int_fail <= 1'b0;
        cyc_n(3);
        chk_bit(disc, 1'b1, "internal fault unseen");
        exp_q.push_back(FC_NONE);
        f_clear <= 1'b1;
        cyc_n(1);
        f_clear <= 1'b0;
        cyc_n(4);
        // Software gate and plain stop while running
        sw_gate_en <= 1'b0;
        cyc_n(3);
        chk_bit(gate_en, 1'b0, "software gate ignored");
        sw_gate_en <= 1'b1;
        stop_cmd <= 1'b1;
        cyc_n(1);
        stop_cmd <= 1'b0;
        cyc_n(3);
        chk_bit(gate_en, 1'b0, "gate on after stop");
        chk_bit(trip, 1'b0, "trip on plain stop");
        run_up();
        chk_bit(exp_q.size() == 0, 1'b1, "codes missing");
        conclude();
    end
endmodule
